//--- core/arct_pkg.sv
package arct_pkg;

    // Control register image, bit positions and reset value
    localparam logic [7:0] ARCT_CTRL_ADDR    = 8'hc8;
    localparam int         ARCT_HI_FLAG_BIT  = 7;
    localparam int         ARCT_LO_FLAG_BIT  = 6;
    localparam int         ARCT_LO_IEN_BIT   = 5;
    localparam int         ARCT_CAP_EN_BIT   = 4;
    localparam int         ARCT_SPLIT_BIT    = 3;
    localparam int         ARCT_RUN_BIT      = 2;
    localparam int         ARCT_UNUSED_BIT   = 1;
    localparam int         ARCT_EXT_SEL_BIT  = 0;
    localparam logic [7:0] ARCT_CTRL_RST     = 8'h00;
    localparam logic [15:0] ARCT_CNT_RST     = 16'h0000;
    localparam logic [15:0] ARCT_RLD_RST     = 16'h0000;

    // Clock prescalers and resync length, in timer clocks
    localparam int         ARCT_SYS_DIV      = 12;
    localparam int         ARCT_EXT_DIV      = 8;
    localparam int         ARCT_SYNC_TICKS   = 3;
    localparam logic [3:0] ARCT_SYS_DIV_LAST = 4'(ARCT_SYS_DIV - 1);
    localparam logic [2:0] ARCT_EXT_DIV_LAST = 3'(ARCT_EXT_DIV - 1);
    localparam logic [1:0] ARCT_SYNC_LAST    = 2'(ARCT_SYNC_TICKS - 1);

    typedef enum logic [1:0] {
        ARCT_MODE_16    = 2'b00,
        ARCT_MODE_SPLIT = 2'b01,
        ARCT_MODE_CAP   = 2'b10
    } arct_mode_e;

    // Software-held configuration bits
    typedef struct packed {
        logic low_ovf_ien;
        logic cap_en;
        logic split_sel;
        logic run;
        logic ext_clk_sel;
        logic fast_hi;
        logic fast_lo;
    } arct_cfg_s;

    // Software write strobes with their data
    typedef struct packed {
        logic        cnt_wr;
        logic [15:0] cnt_data;
        logic        rld_wr;
        logic [15:0] rld_data;
        logic        clr_hi;
        logic        clr_lo;
    } arct_wr_s;

endpackage : arct_pkg

//--- core/arct_timer.sv
`timescale 1ns/1ps

// What this block does
// - Two bytes make a 16-bit counter, or two 8-bit ones under split select.
// - Count clock is system clock, system clock over 12, or external over 8.
// - External over 8 gets synchronised, but drives directly in suspend.
// - In suspend the counter keeps counting; its overflow wakes the device.
// - Wake by another source sets sync busy for up to three timer clocks.
// - 16-bit rollover loads both reload bytes and sets the high flag.
// - In 16-bit mode the timer interrupt fires on every full overflow.
// - With low enable too, each low byte rollover also interrupts.
// - Split mode reloads each byte from its own reload byte.
// - Split mode: run gates only the high byte; low byte always counts.
// - Fast select: system clock; else ext select picks over-12 or over-8.
// - Split mode sets high flag on high rollover, low flag on low rollover.
// - Split interrupts on high overflow, and on low one if low enable set.
// - Hardware never clears the flags; software clears them and checks both.
// - Capture needs capture enable, no split; out of suspend clock is system or over-12.
// - Comparator rise copies counter to reload bytes and sets high flag.
// - Control image: flags, low enable, capture, split, run, zero, ext.
// - Low flag sets on every low byte rollover, in every mode.
module arct_timer
    import arct_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              RST_N,
    input  wire arct_pkg::arct_cfg_s CFG,
    input  wire arct_pkg::arct_wr_s  WR,
    input  wire logic              TIMER_IRQ_EN,
    input  wire logic              EXT_OSC,
    input  wire logic              CMP_OUT,
    input  wire logic              SUSPEND,
    input  wire logic              WAKE_OTHER,
    output logic [15:0]            CNT_VALUE,
    output logic [15:0]            RELOAD_VALUE,
    output logic [7:0]             CTRL_READ,
    output logic                   TIMER_IRQ,
    output logic                   WAKE,
    output logic                   SYNC_BUSY
);
    import arct_pkg::*;

    logic [3:0]  div12_r, div12_nxt;
    logic [2:0]  ext_div_r, ext_div_nxt;
    logic        ext_prev_r, ext_prev_nxt;
    logic        ext_sync_r, ext_sync_nxt;
    logic        cmp_prev_r, cmp_prev_nxt;
    logic        tick12, ext_raw_tick, ext_tick;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] rld_r, rld_nxt;
    logic        hi_flag_r, hi_flag_nxt;
    logic        lo_flag_r, lo_flag_nxt;
    logic        wake_r, wake_nxt;
    logic        busy_r, busy_nxt;
    logic [1:0]  busy_cnt_r, busy_cnt_nxt;
    arct_mode_e  mode;
    logic        lo_tick, hi_tick, ext_sel_eff;
    logic        lo_inc, hi_inc, lo_wrap, hi_wrap, full_wrap, cap_evt;
    logic        hi_set, lo_set, ovf_evt;

    // Tick source for one byte; system clock sources are stopped in suspend
    function automatic logic src_tick(input logic fast, input logic ext_sel,
                                      input logic susp, input logic t12,
                                      input logic text);
        if (susp)
            return text;
        else if (fast)
            return 1'b1;
        else if (ext_sel)
            return text;
        else
            return t12;
    endfunction : src_tick

    // Prescalers
    always_comb begin
        tick12       = (div12_r == ARCT_SYS_DIV_LAST);
        div12_nxt    = tick12 ? 4'h0 : div12_r + 4'h1;
        ext_prev_nxt = EXT_OSC;
        ext_div_nxt  = ext_div_r;
        if (EXT_OSC && !ext_prev_r)
            ext_div_nxt = ext_div_r + 3'h1;
        ext_raw_tick = EXT_OSC && !ext_prev_r
                       && (ext_div_r == ARCT_EXT_DIV_LAST);
        ext_sync_nxt = ext_raw_tick;
        // Extra stage costs a cycle of latency but aligns to the system clock
        ext_tick     = SUSPEND ? ext_raw_tick : ext_sync_r;
        cmp_prev_nxt = CMP_OUT;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            div12_r    <= 4'h0;
            ext_div_r  <= 3'h0;
            ext_prev_r <= 1'b0;
            ext_sync_r <= 1'b0;
            cmp_prev_r <= 1'b0;
        end else begin
            div12_r    <= div12_nxt;
            ext_div_r  <= ext_div_nxt;
            ext_prev_r <= ext_prev_nxt;
            ext_sync_r <= ext_sync_nxt;
            cmp_prev_r <= cmp_prev_nxt;
        end
    end

    // Mode decode and count enables
    always_comb begin
        if (CFG.cap_en && !CFG.split_sel)
            mode = ARCT_MODE_CAP;
        else if (CFG.split_sel)
            mode = ARCT_MODE_SPLIT;
        else
            mode = ARCT_MODE_16;
        // Capture ignores the external select: only fast or over-12 out of suspend
        ext_sel_eff = CFG.ext_clk_sel && (mode != ARCT_MODE_CAP);
        lo_tick = src_tick(CFG.fast_lo, ext_sel_eff, SUSPEND,
                           tick12, ext_tick);
        hi_tick = src_tick(CFG.fast_hi, ext_sel_eff, SUSPEND,
                           tick12, ext_tick);
        lo_inc    = 1'b0;
        hi_inc    = 1'b0;
        full_wrap = 1'b0;
        case (mode)
            ARCT_MODE_SPLIT: begin
                lo_inc = lo_tick;
                hi_inc = CFG.run && hi_tick;
            end
            ARCT_MODE_16, ARCT_MODE_CAP: begin
                lo_inc    = CFG.run && lo_tick;
                full_wrap = lo_inc && (cnt_r == 16'hffff);
            end
            default: begin
                lo_inc = 1'b0;
            end
        endcase
        lo_wrap = lo_inc && (cnt_r[7:0] == 8'hff);
        hi_wrap = (mode == ARCT_MODE_SPLIT) ? hi_inc && (cnt_r[15:8] == 8'hff)
                                            : full_wrap;
        cap_evt = (mode == ARCT_MODE_CAP)
                  && CMP_OUT && !cmp_prev_r;
    end

    // Counter and reload bytes; a software counter write beats counting
    always_comb begin
        cnt_nxt = cnt_r;
        rld_nxt = rld_r;
        case (mode)
            ARCT_MODE_16: begin
                if (full_wrap)
                    cnt_nxt = rld_r;
                else if (lo_inc)
                    cnt_nxt = cnt_r + 16'h0001;
            end
            ARCT_MODE_CAP: begin
                // Free-running so successive captures can be subtracted
                if (lo_inc)
                    cnt_nxt = cnt_r + 16'h0001;
            end
            ARCT_MODE_SPLIT: begin
                if (lo_inc)
                    cnt_nxt[7:0] = lo_wrap ? rld_r[7:0]
                                           : cnt_r[7:0] + 8'h01;
                if (hi_inc)
                    cnt_nxt[15:8] = hi_wrap ? rld_r[15:8]
                                            : cnt_r[15:8] + 8'h01;
            end
            default: begin
                cnt_nxt = cnt_r;
            end
        endcase
        if (WR.cnt_wr)
            cnt_nxt = WR.cnt_data;
        if (WR.rld_wr)
            rld_nxt = WR.rld_data;
        // Hardware capture beats a software reload write in the same cycle
        if (cap_evt)
            rld_nxt = cnt_r;
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cnt_r <= ARCT_CNT_RST;
            rld_r <= ARCT_RLD_RST;
        end else begin
            cnt_r <= cnt_nxt;
            rld_r <= rld_nxt;
        end
    end

    // Sticky flags: the set wins over a clear in the same cycle
    always_comb begin
        hi_set      = hi_wrap || cap_evt;
        lo_set      = lo_wrap;
        hi_flag_nxt = hi_set || (hi_flag_r && !WR.clr_hi);
        lo_flag_nxt = lo_set || (lo_flag_r && !WR.clr_lo);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            hi_flag_r <= ARCT_CTRL_RST[ARCT_HI_FLAG_BIT];
            lo_flag_r <= ARCT_CTRL_RST[ARCT_LO_FLAG_BIT];
        end else begin
            hi_flag_r <= hi_flag_nxt;
            lo_flag_r <= lo_flag_nxt;
        end
    end

    // Suspend wake-up and post-wake resynchronisation
    always_comb begin
        ovf_evt      = hi_wrap;
        wake_nxt     = SUSPEND && ovf_evt;
        busy_nxt     = busy_r;
        busy_cnt_nxt = busy_cnt_r;
        if (WAKE_OTHER) begin
            busy_nxt     = 1'b1;
            busy_cnt_nxt = 2'h0;
        end else if (busy_r && ext_tick) begin
            busy_cnt_nxt = busy_cnt_r + 2'h1;
            if (busy_cnt_r == ARCT_SYNC_LAST)
                busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            wake_r     <= 1'b0;
            busy_r     <= 1'b0;
            busy_cnt_r <= 2'h0;
        end else begin
            wake_r     <= wake_nxt;
            busy_r     <= busy_nxt;
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    // Outputs
    always_comb begin
        CNT_VALUE    = cnt_r;
        RELOAD_VALUE = rld_r;
        CTRL_READ    = ARCT_CTRL_RST;
        CTRL_READ[ARCT_HI_FLAG_BIT] = hi_flag_r;
        CTRL_READ[ARCT_LO_FLAG_BIT] = lo_flag_r;
        CTRL_READ[ARCT_LO_IEN_BIT]  = CFG.low_ovf_ien;
        CTRL_READ[ARCT_CAP_EN_BIT]  = CFG.cap_en;
        CTRL_READ[ARCT_SPLIT_BIT]   = CFG.split_sel;
        CTRL_READ[ARCT_RUN_BIT]     = CFG.run;
        CTRL_READ[ARCT_UNUSED_BIT]  = 1'b0;
        CTRL_READ[ARCT_EXT_SEL_BIT] = CFG.ext_clk_sel;
        TIMER_IRQ = TIMER_IRQ_EN && hi_flag_r;
        if (TIMER_IRQ_EN && CFG.low_ovf_ien && lo_flag_r)
            TIMER_IRQ = 1'b1;
        WAKE      = wake_r;
        SYNC_BUSY = busy_r;
    end

    default clocking arct_cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    a_div12_period: assert property (
        tick12 |=> (!tick12) [*8] ##1 (!tick12) [*3] ##1 tick12)
        else $error("over-12 prescaler period wrong");

    a_full_reload: assert property (
        (mode == ARCT_MODE_16) && full_wrap && !WR.cnt_wr
        |=> (cnt_r == $past(rld_r)) && hi_flag_r)
        else $error("16-bit overflow did not reload and flag");

    a_lo_flag_set: assert property (
        lo_inc && (cnt_r[7:0] == 8'hff) |=> lo_flag_r)
        else $error("low rollover did not set low flag");

    a_flag_sticky: assert property (
        hi_flag_r && !WR.clr_hi |=> hi_flag_r)
        else $error("high flag dropped without a clear");

    a_split_hi_gated: assert property (
        CFG.split_sel && !CFG.run && !WR.cnt_wr
        |=> cnt_r[15:8] == $past(cnt_r[15:8]))
        else $error("split high byte moved while stopped");

    a_split_lo_free: assert property (
        CFG.split_sel && lo_tick && !WR.cnt_wr && (cnt_r[7:0] != 8'hff)
        |=> cnt_r[7:0] == $past(cnt_r[7:0]) + 8'h01)
        else $error("split low byte did not count");

    a_capture_copy: assert property (
        CFG.cap_en && !CFG.split_sel && $rose(CMP_OUT)
        |-> ##1 (rld_r == $past(cnt_r)) && hi_flag_r)
        else $error("capture did not copy counter");

    a_irq_level: assert property (
        TIMER_IRQ_EN && hi_flag_r |-> TIMER_IRQ)
        else $error("interrupt missing with high flag set");

    a_lo_irq_level: assert property (
        TIMER_IRQ_EN && CFG.low_ovf_ien && lo_flag_r |-> TIMER_IRQ)
        else $error("interrupt missing with low flag set");

    a_wake_on_ovf: assert property (
        SUSPEND && hi_wrap |=> WAKE)
        else $error("suspend overflow did not wake");

    a_busy_set: assert property (
        WAKE_OTHER |=> SYNC_BUSY && (busy_cnt_r == 2'h0))
        else $error("sync busy not raised on wake");

endmodule : arct_timer

//--- sim/arct_far_model.sv
`timescale 1ns/1ps

// Comparator and external oscillator as the timer sees them
module arct_far_model (
    input  wire logic CLK_SYS,
    input  wire logic cmp_level,
    output logic      ext_osc,
    output logic      cmp_out
);
    // A crystal runs free, so the oscillator never stops between tests
    initial ext_osc = 1'b0;
    always @(posedge CLK_SYS) ext_osc <= #1 ~ext_osc;
    // Comparator settles one clock after the requested level
    initial cmp_out = 1'b0;
    always @(posedge CLK_SYS) cmp_out <= #1 cmp_level;
endmodule : arct_far_model

//--- sim/testbench.sv
`timescale 1ns/1ps

module testbench;
    import arct_pkg::*;
    logic        clk_sys;
    logic        rst_n;
    logic        irq_en;
    logic        suspend;
    logic        wake_other;
    logic        cmp_level;
    logic        ext_osc;
    logic        cmp_out;
    logic        irq;
    logic        wake;
    logic        busy;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] r1;
    logic [7:0]  ctrl;
    arct_cfg_s   cfg;
    arct_wr_s    wr;
    int          err_total;
    int          checks_done;
    int          n;

    arct_far_model u_far (.CLK_SYS(clk_sys), .cmp_level(cmp_level),
        .ext_osc(ext_osc), .cmp_out(cmp_out));
    arct_timer u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .CFG(cfg),
        .WR(wr), .TIMER_IRQ_EN(irq_en), .EXT_OSC(ext_osc),
        .CMP_OUT(cmp_out), .SUSPEND(suspend), .WAKE_OTHER(wake_other),
        .CNT_VALUE(cnt), .RELOAD_VALUE(rld), .CTRL_READ(ctrl),
        .TIMER_IRQ(irq), .WAKE(wake), .SYNC_BUSY(busy));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic load(input logic [15:0] c, input logic [15:0] r);
        wr.cnt_wr   = 1'b1;
        wr.cnt_data = c;
        wr.rld_wr   = 1'b1;
        wr.rld_data = r;
        tick();
        wr.cnt_wr   = 1'b0;
        wr.rld_wr   = 1'b0;
    endtask : load

    task automatic clear();
        wr.clr_hi = 1'b1;
        wr.clr_lo = 1'b1;
        tick();
        wr.clr_hi = 1'b0;
        wr.clr_lo = 1'b0;
    endtask : clear

    task automatic wait_ctrl(input int b);
        int k;
        k = 0;
        while (ctrl[b] !== 1'b1 && k < 400) begin
            tick();
            k++;
        end
        check({15'h0, ctrl[b]}, 16'h0001);
    endtask : wait_ctrl

    // Cycles between two increments; the first change only aligns
    task automatic gap(input logic [15:0] exp);
        logic [15:0] v;
        int          k;
        for (int i = 0; i < 2; i++) begin
            v = cnt;
            k = 0;
            while (cnt === v && k < 100) begin
                tick();
                k++;
            end
        end
        check(16'(k), exp);
    endtask : gap

    task automatic print_verdict();
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        cfg = '0;
        wr = '0;
        irq_en = 1'b1;
        suspend = 1'b0;
        wake_other = 1'b0;
        cmp_level = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check(cnt, 16'h0000);
        check({8'h0, ctrl}, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        cfg = 7'h7c;
        tick();
        check({8'h0, ctrl}, 16'h003d);
        cfg = '0;
        load(16'hfffd, 16'h1234);
        cfg.fast_lo = 1'b1;
        cfg.run = 1'b1;
        wait_ctrl(7);
        check(cnt, 16'h1234);
        check({15'h0, ctrl[6]}, 16'h0001);
        check({15'h0, irq}, 16'h0001);
        repeat (5) tick();
        check({14'h0, ctrl[7:6]}, 16'h0003);
        cfg.run = 1'b0;
        clear();
        check({14'h0, ctrl[7:6]}, 16'h0000);
        load(16'h00fd, 16'h0000);
        cfg.run = 1'b1;
        wait_ctrl(6);
        check({15'h0, ctrl[7]}, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        cfg.low_ovf_ien = 1'b1;
        tick();
        check({15'h0, irq}, 16'h0001);
        cfg = 7'h13;
        clear();
        load(16'hfffe, 16'h5580);
        wait_ctrl(6);
        check(cnt, 16'hff80);
        check({15'h0, irq}, 16'h0000);
        cfg.run = 1'b1;
        wait_ctrl(7);
        check({8'h0, cnt[15:8]}, 16'h0055);
        check({15'h0, irq}, 16'h0001);
        cfg = 7'h10;
        clear();
        gap(16'd12);
        cfg.ext_clk_sel = 1'b1;
        gap(16'd16);
        cfg.fast_lo = 1'b1;
        gap(16'd1);
        cfg = 7'h29;
        load(16'h0100, 16'h0000);
        clear();
        // Two rising edges forty clocks apart; only the difference is fixed
        cmp_level = 1'b1;
        repeat (3) tick();
        r1 = rld;
        tick();
        cmp_level = 1'b0;
        repeat (36) tick();
        cmp_level = 1'b1;
        repeat (3) tick();
        check(rld - r1, 16'd40);
        check({15'h0, ctrl[7]}, 16'h0001);
        check({15'h0, irq}, 16'h0001);
        cmp_level = 1'b0;
        r1 = rld;
        cfg.split_sel = 1'b1;
        repeat (3) tick();
        cmp_level = 1'b1;
        repeat (3) tick();
        check(rld, r1);
        cmp_level = 1'b0;
        cfg = 7'h0c;
        clear();
        load(16'hfffe, 16'h0000);
        suspend = 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        check({15'h0, wake}, 16'h0001);
        tick();
        check({15'h0, wake}, 16'h0000);
        suspend = 1'b0;
        wake_other = 1'b1;
        tick();
        wake_other = 1'b0;
        check({15'h0, busy}, 16'h0001);
        repeat (20) tick();
        check({15'h0, busy}, 16'h0001);
        repeat (60) tick();
        check({15'h0, busy}, 16'h0000);
        print_verdict();
    end
endmodule : testbench
